// [core/cwlo_top.sv]
// Overview of operation
// - After reset the clocking mode is sixteen-times, the most accurate mode.
// - Sixteen-times mode derives sixteen equally spaced LO phases from the fast clock.
// - Sync clock rising edge realigns the divider so all devices share phase.
// - Each of sixteen mixer clocks is picked by a sixteen-way cross-point.
// - Each phase step is one sixteenth period, 22.5 degrees, per channel.
// - Eight- and four-times modes make I and Q clocks exactly 90 degrees apart.
// - Harmonic suppression is offered in eight-times mode, never in four-times.
// - Intermediate phases come from cosine and sine weights of the target angle.
// - One-times mode feeds both clock inputs straight to the mixers.
// - In divided modes the sync clock only aligns, never demodulates.
// - LO is the fast clock divided by sixteen, eight or four.
// - Other modes support CW signals up to 15 MHz.
// - Two clock inputs, fast at N times and sync at one times, N selectable.
// - Enabling the CW path disables the time-gain path.
`timescale 1ns/10ps
module cwlo_top
    import cwlo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic doppler_fast_clock_in,
    input wire logic doppler_sync_clock_in,
    output logic [NUM_CH-1:0] mix_clk_i,
    output logic [NUM_CH-1:0] mix_clk_q,
    output logic [NUM_CH*WEIGHT_W-1:0] mix_weight_cos,
    output logic [NUM_CH*WEIGHT_W-1:0] mix_weight_sin,
    output logic harm_suppress_en,
    output logic time_gain_path_en
);
    logic [CTRL_W-1:0] ctrl_r;
    logic [NUM_CH*PHASE_W-1:0] ch_sel_r;
    logic [DATA_W-1:0] prdata_r;
    logic [PHASE_W-1:0] cnt_r;
    logic [PHASE_W-1:0] cnt_nxt;
    cwlo_mode_t mode_act_r;
    cwlo_mode_t mode_pend;
    logic aligned_r;
    logic fast_lvl;
    logic fast_rise;
    logic sync_lvl;
    logic sync_rise;
    logic [NUM_PHASES-1:0] lo_vec;
    logic [NUM_PHASES-1:0] direct_vec;
    logic [NUM_PHASES-1:0] phase_vec;
    logic [PHASE_W-1:0] step;
    logic cw_en;
    logic quad_mode;
    logic is_1x;

    // APB decode
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_sel_lo;
    logic hit_sel_hi;
    logic mapped;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] status_word;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_stat = (paddr == ADDR_STATUS);
    assign hit_sel_lo = (paddr == ADDR_SEL_LO);
    assign hit_sel_hi = (paddr == ADDR_SEL_HI);
    assign mapped = hit_ctrl | hit_stat | hit_sel_lo | hit_sel_hi;
    assign wr_en = access_ph & pwrite & clk_en;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;

    assign status_word = DATA_W'({cnt_r, mode_act_r, (mode_pend != mode_act_r), aligned_r,
                                  time_gain_path_en, cw_en});
    assign rd_mux = hit_ctrl ? DATA_W'(ctrl_r) :
                    hit_stat ? status_word :
                    hit_sel_lo ? ch_sel_r[0 +: DATA_W] :
                    hit_sel_hi ? ch_sel_r[DATA_W +: DATA_W] : '0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= '0;
        end else if (clk_en && setup_ph && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end
    assign prdata = prdata_r;

    // Configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_en && hit_ctrl) begin
            ctrl_r <= pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_sel_r <= {SEL_RST, SEL_RST};
        end else if (wr_en && hit_sel_lo) begin
            ch_sel_r[0 +: DATA_W] <= pwdata;
        end else if (wr_en && hit_sel_hi) begin
            ch_sel_r[DATA_W +: DATA_W] <= pwdata;
        end
    end

    assign cw_en = ctrl_r[CTRL_CW_EN_BIT];
    assign time_gain_path_en = ~cw_en;

    always_comb begin
        unique case (ctrl_r[CTRL_MODE_LSB +: CTRL_MODE_W])
            MODE_CODE_16X: mode_pend = CWLO_M16;
            MODE_CODE_8X: mode_pend = CWLO_M8;
            MODE_CODE_4X: mode_pend = CWLO_M4;
            MODE_CODE_1X: mode_pend = CWLO_M1;
        endcase
    end

    // Clock inputs, sampled as synchronous levels
    cwlo_edge u_fast_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sig_in(doppler_fast_clock_in),
        .level(fast_lvl),
        .rise(fast_rise)
    );

    cwlo_edge u_sync_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sig_in(doppler_sync_clock_in),
        .level(sync_lvl),
        .rise(sync_rise)
    );

    // Mode switches only at the sync edge so the divider restarts cleanly
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_act_r <= CWLO_M16;
        end else if (clk_en && sync_rise) begin
            mode_act_r <= mode_pend;
        end
    end

    assign is_1x = (mode_act_r == CWLO_M1);
    assign quad_mode = (mode_act_r == CWLO_M8) | (mode_act_r == CWLO_M4) | is_1x;

    // Advance in sixteenths: divide by 16, 8 or 4
    always_comb begin
        unique case (mode_act_r)
            CWLO_M16: step = STEP_16X;
            CWLO_M8: step = STEP_8X;
            CWLO_M4: step = STEP_4X;
            CWLO_M1: step = CNT_ALIGN;
            default: step = STEP_16X;
        endcase
    end

    assign cnt_nxt = sync_rise ? CNT_ALIGN :
                     fast_rise ? PHASE_W'(cnt_r + step) : cnt_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= CNT_ALIGN;
            aligned_r <= 1'b0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
            aligned_r <= aligned_r | sync_rise;
        end
    end

    // Sixteen phases 22.5 degrees apart; 1X takes inputs directly
    generate
        for (genvar k = 0; k < NUM_PHASES; k++) begin : g_phase
            assign lo_vec[k] = PHASE_W'(cnt_r - PHASE_W'(k)) < HALF_PERIOD;
            if ((k / 4) == 0) begin : g_q0
                assign direct_vec[k] = fast_lvl;
            end else if ((k / 4) == 1) begin : g_q1
                assign direct_vec[k] = sync_lvl;
            end else if ((k / 4) == 2) begin : g_q2
                assign direct_vec[k] = ~fast_lvl;
            end else begin : g_q3
                assign direct_vec[k] = ~sync_lvl;
            end
        end
    endgenerate

    assign phase_vec = is_1x ? direct_vec : lo_vec;

    // Cross-point, one per channel
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            cwlo_xpoint u_xp (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .enable(cw_en),
                .quad_mode(quad_mode),
                .phases(phase_vec),
                .sel(ch_sel_r[c*PHASE_W +: PHASE_W]),
                .mix_i(mix_clk_i[c]),
                .mix_q(mix_clk_q[c]),
                .w_cos(mix_weight_cos[c*WEIGHT_W +: WEIGHT_W]),
                .w_sin(mix_weight_sin[c*WEIGHT_W +: WEIGHT_W])
            );
        end
    endgenerate

    assign harm_suppress_en = cw_en & ctrl_r[CTRL_HS_BIT]
                              & ((mode_act_r == CWLO_M16) | (mode_act_r == CWLO_M8));

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_tgp_off;
        cw_en |-> !time_gain_path_en;
    endproperty
    a_tgp_off: assert property (p_tgp_off) else $error("time gain path on with CW enabled");

    property p_sync_align;
        clk_en && sync_rise |=> cnt_r == CNT_ALIGN;
    endproperty
    a_sync_align: assert property (p_sync_align) else $error("divider not realigned on sync");

    property p_step8;
        clk_en && fast_rise && !sync_rise && mode_act_r == CWLO_M8 |=> PHASE_W'(cnt_r - $past(cnt_r)) == STEP_8X;
    endproperty
    a_step8: assert property (p_step8) else $error("8X divider step wrong");

    property p_step16;
        clk_en && fast_rise && !sync_rise && mode_act_r == CWLO_M16 |=> PHASE_W'(cnt_r - $past(cnt_r)) == STEP_16X;
    endproperty
    a_step16: assert property (p_step16) else $error("16X divider step wrong");

    property p_mode_hold;
        !(clk_en && sync_rise) |=> $stable(mode_act_r);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without sync edge");

    property p_quad;
        quad_mode |-> (phase_vec[0] != phase_vec[8]) && (phase_vec[QUAD_OFFSET] != phase_vec[12]);
    endproperty
    a_quad: assert property (p_quad) else $error("quadrature phases not opposed");

    property p_direct;
        is_1x |-> phase_vec[0] == fast_lvl && phase_vec[QUAD_OFFSET] == sync_lvl;
    endproperty
    a_direct: assert property (p_direct) else $error("1X mode not using inputs directly");

    property p_hs;
        harm_suppress_en |-> mode_act_r != CWLO_M4 && mode_act_r != CWLO_M1;
    endproperty
    a_hs: assert property (p_hs) else $error("harmonic suppression in 4X or 1X");

    property p_sel_wr;
        wr_en && hit_sel_lo |=> ch_sel_r[PHASE_W-1:0] == $past(pwdata[PHASE_W-1:0]);
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("phase select not stored");

    property p_ch0_16x;
        clk_en && cw_en && mode_act_r == CWLO_M16 |=> mix_clk_i[0] == $past(phase_vec[ch_sel_r[PHASE_W-1:0]]);
    endproperty
    a_ch0_16x: assert property (p_ch0_16x) else $error("channel 0 cross-point wrong");

    property p_step4;
        clk_en && fast_rise && !sync_rise && mode_act_r == CWLO_M4 |=> PHASE_W'(cnt_r - $past(cnt_r)) == STEP_4X;
    endproperty
    a_step4: assert property (p_step4) else $error("4X divider step wrong");

    property p_hold_1x;
        clk_en && fast_rise && !sync_rise && is_1x |=> $stable(cnt_r);
    endproperty
    a_hold_1x: assert property (p_hold_1x) else $error("divider moved in 1X mode");

    property p_aligned_set;
        clk_en && sync_rise |=> aligned_r;
    endproperty
    a_aligned_set: assert property (p_aligned_set) else $error("aligned flag not set on sync");

    property p_aligned_keep;
        aligned_r |=> aligned_r;
    endproperty
    a_aligned_keep: assert property (p_aligned_keep) else $error("aligned flag dropped");

    property p_mode_take;
        clk_en && sync_rise |=> mode_act_r == $past(mode_pend);
    endproperty
    a_mode_take: assert property (p_mode_take) else $error("pending mode not applied on sync");

    property p_ch0_q16;
        clk_en && cw_en && mode_act_r == CWLO_M16
            |=> mix_clk_q[0] == $past(phase_vec[PHASE_W'(ch_sel_r[PHASE_W-1:0] + QUAD_OFFSET)]);
    endproperty
    a_ch0_q16: assert property (p_ch0_q16) else $error("channel 0 quadrature pick wrong");

    property p_quad_i;
        clk_en && cw_en && quad_mode |=> mix_clk_i[0] == $past(phase_vec[0]);
    endproperty
    a_quad_i: assert property (p_quad_i) else $error("in-phase clock not phase 0");

    property p_quad_q;
        clk_en && cw_en && quad_mode |=> mix_clk_q[0] == $past(phase_vec[QUAD_OFFSET]);
    endproperty
    a_quad_q: assert property (p_quad_q) else $error("quadrature clock not a quarter later");

    property p_w16;
        clk_en && cw_en && mode_act_r == CWLO_M16
            |=> mix_weight_cos[WEIGHT_W-1:0] == WEIGHT_ONE && mix_weight_sin[WEIGHT_W-1:0] == WEIGHT_ZERO;
    endproperty
    a_w16: assert property (p_w16) else $error("16X weights not unity");

    property p_wquad;
        clk_en && cw_en && quad_mode
            |=> mix_weight_cos[WEIGHT_W-1:0] == $past(COS_TAB[ch_sel_r[PHASE_W-1:0]*WEIGHT_W +: WEIGHT_W]);
    endproperty
    a_wquad: assert property (p_wquad) else $error("rotation weight wrong");

    property p_cw_off;
        clk_en && !cw_en |=> mix_clk_i == '0 && mix_clk_q == '0;
    endproperty
    a_cw_off: assert property (p_cw_off) else $error("mixer clocks active with CW off");

    property p_hs_on;
        cw_en && ctrl_r[CTRL_HS_BIT] && mode_act_r == CWLO_M8 |-> harm_suppress_en;
    endproperty
    a_hs_on: assert property (p_hs_on) else $error("harmonic suppression missing in 8X");

    property p_freeze;
        !clk_en |=> $stable(ctrl_r) && $stable(ch_sel_r) && $stable(cnt_r) && $stable(mode_act_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state changed with clock enable low");
endmodule : cwlo_top

// [core/cwlo_pkg.sv]
package cwlo_pkg;
    localparam int NUM_CH = 16;
    localparam int NUM_PHASES = 16;
    localparam int PHASE_W = 4;
    localparam int WEIGHT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_WORD_CH = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SEL_LO = 8'h08;
    localparam logic [7:0] ADDR_SEL_HI = 8'h0C;

    // Control register fields
    localparam int CTRL_CW_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_W = 2;
    localparam int CTRL_HS_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;

    // Status register fields
    localparam int STAT_CW_EN_BIT = 0;
    localparam int STAT_TGP_BIT = 1;
    localparam int STAT_ALIGNED_BIT = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_CNT_LSB = 8;

    // Mode field codes
    localparam logic [1:0] MODE_CODE_16X = 2'h0;
    localparam logic [1:0] MODE_CODE_8X = 2'h1;
    localparam logic [1:0] MODE_CODE_4X = 2'h2;
    localparam logic [1:0] MODE_CODE_1X = 2'h3;

    typedef enum logic [3:0] {
        CWLO_M16 = 4'b0001,
        CWLO_M8 = 4'b0010,
        CWLO_M4 = 4'b0100,
        CWLO_M1 = 4'b1000
    } cwlo_mode_t;

    // Divider advance per fast-clock edge, in sixteenths of the LO period
    localparam logic [3:0] STEP_16X = 4'h1;
    localparam logic [3:0] STEP_8X = 4'h2;
    localparam logic [3:0] STEP_4X = 4'h4;
    localparam logic [3:0] QUAD_OFFSET = 4'h4;
    localparam logic [3:0] HALF_PERIOD = 4'h8;
    localparam logic [3:0] CNT_ALIGN = 4'h0;

    // Signal band limits in MHz
    localparam int FAST_MAX_16X_MHZ = 128;
    localparam int CW_MAX_16X_MHZ = 8;
    localparam int CW_MAX_OTHER_MHZ = 15;

    // Weights in steps of 22.5 degrees, index 0 in the low byte
    localparam logic [7:0] WEIGHT_ONE = 8'h7F;
    localparam logic [7:0] WEIGHT_ZERO = 8'h00;
    localparam logic [127:0] COS_TAB =
        128'h755A_3100_CFA6_8B81_8BA6_CF00_315A_757F;
    localparam logic [127:0] NSIN_TAB =
        128'h315A_757F_755A_3100_CFA6_8B81_8BA6_CF00;
endpackage : cwlo_pkg

// [core/cwlo_edge.sv]
`timescale 1ns/10ps
module cwlo_edge
    import cwlo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sig_in,
    output logic level,
    output logic rise
);
    logic level_r;
    logic prev_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (clk_en) begin
            level_r <= sig_in;
            prev_r <= level_r;
        end
    end

    assign level = level_r;
    assign rise = level_r & ~prev_r;
endmodule : cwlo_edge

// [core/cwlo_xpoint.sv]
`timescale 1ns/10ps
module cwlo_xpoint
    import cwlo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic quad_mode,
    input wire logic [NUM_PHASES-1:0] phases,
    input wire logic [PHASE_W-1:0] sel,
    output logic mix_i,
    output logic mix_q,
    output logic [WEIGHT_W-1:0] w_cos,
    output logic [WEIGHT_W-1:0] w_sin
);
    logic mix_i_r;
    logic mix_q_r;
    logic [WEIGHT_W-1:0] w_cos_r;
    logic [WEIGHT_W-1:0] w_sin_r;
    logic [PHASE_W-1:0] q_idx;
    logic i_nxt;
    logic q_nxt;
    logic [WEIGHT_W-1:0] cos_nxt;
    logic [WEIGHT_W-1:0] sin_nxt;

    // Direct phase pick in 16X; fixed I/Q plus rotation weights otherwise
    assign q_idx = quad_mode ? QUAD_OFFSET : PHASE_W'(sel + QUAD_OFFSET);
    assign i_nxt = enable & (quad_mode ? phases[0] : phases[sel]);
    assign q_nxt = enable & phases[q_idx];
    assign cos_nxt = !enable ? WEIGHT_ZERO : quad_mode ? COS_TAB[sel*WEIGHT_W +: WEIGHT_W] : WEIGHT_ONE;
    assign sin_nxt = (enable && quad_mode) ? NSIN_TAB[sel*WEIGHT_W +: WEIGHT_W] : WEIGHT_ZERO;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mix_i_r <= 1'b0;
            mix_q_r <= 1'b0;
            w_cos_r <= WEIGHT_ZERO;
            w_sin_r <= WEIGHT_ZERO;
        end else if (clk_en) begin
            mix_i_r <= i_nxt;
            mix_q_r <= q_nxt;
            w_cos_r <= cos_nxt;
            w_sin_r <= sin_nxt;
        end
    end

    assign mix_i = mix_i_r;
    assign mix_q = mix_q_r;
    assign w_cos = w_cos_r;
    assign w_sin = w_sin_r;
endmodule : cwlo_xpoint

// [sim/cwlo_clk_src.sv]
`timescale 1ns/10ps
module cwlo_clk_src #(
    parameter int HALF = 2 // Fast clock well under 128 MHz and ref_clk/2
) (
    input wire logic ref_clk,
    output logic fast_clk,
    output logic sync_clk
);
    initial begin
        fast_clk = 1'b0;
        sync_clk = 1'b0;
    end

    // One sync rise, then a burst of fast pulses; both stand still afterwards
    task automatic frame(input int pulses);
        begin
            @(posedge ref_clk);
            sync_clk <= 1'b1;
            fast_clk <= 1'b0;
            for (int i = 0; i < pulses; i++) begin
                repeat (HALF) @(posedge ref_clk);
                fast_clk <= 1'b1;
                repeat (HALF) @(posedge ref_clk);
                fast_clk <= 1'b0;
            end
            repeat (HALF) @(posedge ref_clk);
            sync_clk <= 1'b0;
        end
    endtask : frame

    // Static I and Q levels for one-times mode
    task automatic levels(input logic f, input logic s);
        begin
            @(posedge ref_clk);
            fast_clk <= f;
            sync_clk <= s;
        end
    endtask : levels
endmodule : cwlo_clk_src

// [sim/cwlo_top_bench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module cwlo_top_bench;
    import cwlo_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic pready;
    logic pslverr;
    logic sl;
    logic fast;
    logic sync;
    logic hs;
    logic tgp;
    logic [NUM_CH-1:0] mi;
    logic [NUM_CH-1:0] mq;
    logic [NUM_CH*WEIGHT_W-1:0] wc;
    logic [NUM_CH*WEIGHT_W-1:0] ws;
    int err_count = 0;
    int compares = 0;
    int cnt;
    int s;
    int pulses [4] = '{11, 5, 2, 1};

    always #4 ref_clk = ~ref_clk;

    cwlo_clk_src cwlo_clk_src_inst (.ref_clk(ref_clk), .fast_clk(fast), .sync_clk(sync));

    cwlo_top cwlo_top_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .doppler_fast_clock_in(fast), .doppler_sync_clock_in(sync),
        .mix_clk_i(mi), .mix_clk_q(mq), .mix_weight_cos(wc), .mix_weight_sin(ws),
        .harm_suppress_en(hs), .time_gain_path_en(tgp)
    );

    // Level of phase k for divider count c
    function automatic logic ph(input int c, input int k);
        ph = ((c - k) & 15) < 8;
    endfunction : ph

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1) begin
                @(posedge ref_clk);
            end
            rd = prdata;
            sl = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : apb

    task automatic run_frame(input int n);
        begin
            cwlo_clk_src_inst.frame(n);
            repeat (6) @(posedge ref_clk);
        end
    endtask : run_frame

    task automatic wrap_up;
        begin
            $display("compares %0d err_count %0d", compares, err_count);
            if (err_count == 0 && compares > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask : wrap_up

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        `CHK("tgp_rst", 1'b1, tgp)
        apb(0, ADDR_CTRL, 0);
        `CHK("ctrl_rst", 32'h0000_0000, rd)
        apb(0, ADDR_STATUS, 0);
        `CHK("mode_rst", 4'h1, rd[7:4])
        `CHK("aligned_rst", 1'b0, rd[2])
        apb(1, ADDR_SEL_LO, 32'h7654_3210);
        apb(1, ADDR_SEL_HI, 32'hFEDC_BA98);
        apb(0, ADDR_SEL_HI, 0);
        `CHK("sel_hi", 32'hFEDC_BA98, rd)
        `CHK("mapped_err", 1'b0, sl)
        clk_en <= 1'b0;
        apb(1, ADDR_SEL_LO, 32'h0000_0000);
        clk_en <= 1'b1;
        apb(0, ADDR_SEL_LO, 0);
        `CHK("sel_frozen", 32'h7654_3210, rd)
        apb(0, 8'h10, 0);
        `CHK("unmapped_err", 1'b1, sl)
        `CHK("unmapped_rd", 32'h0000_0000, rd)
        apb(1, ADDR_CTRL, 32'h0000_0009);
        `CHK("tgp_cw", 1'b0, tgp)
        for (int m = 0; m < 4; m++) begin
            apb(1, ADDR_CTRL, 32'(9 + (m << 1)));
            if (m > 0) begin
                apb(0, ADDR_STATUS, 0);
                `CHK("mode_hold", 4'(1 << (m - 1)), rd[7:4])
                `CHK("pending", 1'b1, rd[3])
            end
            // Second frame proves the count restarts at every sync rise
            run_frame(7);
            run_frame(pulses[m]);
            cnt = (pulses[m] << m) & 15;
            apb(0, ADDR_STATUS, 0);
            `CHK("mode_act", 4'(1 << m), rd[7:4])
            `CHK("aligned", 1'b1, rd[2])
            `CHK("pend_clr", 1'b0, rd[3])
            `CHK("phase_cnt", (m < 3) ? 4'(cnt) : CNT_ALIGN, rd[11:8])
            `CHK("harm_sup", (m < 2), hs)
            if (m == 3) begin
                for (int f = 0; f < 2; f++) begin
                    cwlo_clk_src_inst.levels(f[0], !f[0]);
                    repeat (6) @(posedge ref_clk);
                    `CHK("mix_i_1x", {NUM_CH{f[0]}}, mi)
                    `CHK("mix_q_1x", {NUM_CH{!f[0]}}, mq)
                end
            end
            for (int c = 0; c < NUM_CH; c++) begin
                s = (m == 0) ? c : 0;
                if (m < 3) begin
                    `CHK("mix_i", ph(cnt, s), mi[c])
                    `CHK("mix_q", ph(cnt, s + 4), mq[c])
                end
                `CHK("w_cos", (m == 0) ? WEIGHT_ONE : COS_TAB[c*8+:8], wc[c*8+:8])
                `CHK("w_sin", (m == 0) ? WEIGHT_ZERO : NSIN_TAB[c*8+:8], ws[c*8+:8])
            end
        end
        apb(1, ADDR_CTRL, 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        `CHK("tgp_off", 1'b1, tgp)
        `CHK("mix_off", 16'h0000, mi)
        wrap_up();
    end

    // The tests need under 3000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end
endmodule : cwlo_top_bench
